/* File: rtl/net_cfg_defs.svh */
`ifndef NET_CFG_DEFS_SVH
`define NET_CFG_DEFS_SVH
// Feature word bit positions.
`define FEAT_DEV_CSUM          0
`define FEAT_DRV_CSUM          1
`define FEAT_OFFLOAD_CTRL      2
`define FEAT_STATION_ADDR      5
`define FEAT_ANY_SEG_LEGACY    6
`define FEAT_DRV_TCP4_SEG      7
`define FEAT_DRV_TCP6_SEG      8
`define FEAT_DRV_CONG_SEG      9
`define FEAT_DRV_UDP_FRAG      10
`define FEAT_DEV_TCP4_SEG      11
`define FEAT_DEV_TCP6_SEG      12
`define FEAT_DEV_CONG_SEG      13
`define FEAT_DEV_UDP_FRAG      14
`define FEAT_MERGE_RX          15
`define FEAT_STATUS            16
`define FEAT_CTRL_QUEUE        17
`define FEAT_CTRL_RX_MODE      18
`define FEAT_CTRL_VLAN         19
`define FEAT_DRV_ANNOUNCE      21
`define FEAT_MULTIQUEUE        22
`define FEAT_CTRL_ADDR_SET     23
// Register byte offsets.
`define OFF_DEV_FEAT           12'h000
`define OFF_DRV_FEAT           12'h004
`define OFF_CONTROL            12'h008
`define OFF_NEG_STATUS         12'h00C
`define OFF_QP_CMD             12'h010
`define OFF_ACTIVE_QP          12'h014
`define OFF_CFG_WORD0          12'h100
`define OFF_CFG_WORD1          12'h104
`define OFF_CFG_WORD2          12'h108
// Control register fields.
`define CTL_LEGACY             0
`define CTL_LINK_UP            1
`define CTL_ANNOUNCE           2
// Status word bit values.
`define LINK_UP_VAL            16'h0001
`define ANNOUNCE_VAL           16'h0002
// Queue-pair limits.
`define QP_MIN                 16'h0001
`define QP_MAX                 16'h8000
// Bus answer codes.
`define RESP_OKAY              2'h0
`define RESP_SLVERR            2'h2
`endif

/* File: rtl/net_cfg_pkg.sv */
package net_cfg_pkg;
    // Outcome of the last driver feature acceptance.
    typedef enum logic [1:0] {
        NEG_NONE   = 2'h0,
        NEG_OK     = 2'h1,
        NEG_REJECT = 2'h2
    } neg_result_t;
    // Read channel states.
    typedef enum logic [1:0] {
        RD_IDLE = 2'b01,
        RD_RESP = 2'b10
    } rd_state_t;
endpackage : net_cfg_pkg

/* File: rtl/net_feature_config_space.sv */
// The implementer's own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/100ps
`include "net_cfg_defs.svh"
// Notes on behaviour
// - Bits 0/1: device and driver partial checksum.
// - Bit 2 offload control, bit 5 address.
// - Bits 7-10 driver receive segmentation kinds.
// - Bits 11-14 device accept segmentation kinds.
// - Bit 15 merge receive buffers.
// - Bit 16 status word present.
// - Bits 17-19 control queue, rx mode, VLAN.
// - Bits 21-23 announce, multiqueue, address set.
// - Dependent features require their prerequisites.
// - Congestion marking needs TCPv4 or TCPv6 segmentation.
// - Legacy bit 6 means any segmentation.
// - Address, status, queue pairs, little endian.
// - Address always present, valid with feature.
// - Status: 1 link up, 2 announce.
// - Queue-pair field only with multiqueue.
// - Queue-pair maximum kept within 1..0x8000.
// - Legacy uses native order for 16-bit fields.
// - Legacy makes station address driver writable.
// - Driver sets up N queue pairs plus control.
// - Only first queues used until pair command.
// - Queue index mapping, control at 2N+2.
module net_feature_config_space (
    // Clock and reset.
    input  wire logic        CLK,
    input  wire logic        RSTN,
    // Device capability inputs.
    input  wire logic [31:0] DEV_FEATURES,
    input  wire logic [47:0] STATION_ADDR_IN,
    input  wire logic [15:0] MAX_QP_IN,
    input  wire logic        NATIVE_BIG_ENDIAN,
    // Write address channel.
    input  wire logic [11:0] AWADDR,
    input  wire logic        AWVALID,
    output logic             AWREADY,
    // Write data channel.
    input  wire logic [31:0] WDATA,
    input  wire logic [3:0]  WSTRB,
    input  wire logic        WVALID,
    output logic             WREADY,
    // Write response channel.
    output logic [1:0]       BRESP,
    output logic             BVALID,
    input  wire logic        BREADY,
    // Read address channel.
    input  wire logic [11:0] ARADDR,
    input  wire logic        ARVALID,
    output logic             ARREADY,
    // Read data channel.
    output logic [31:0]      RDATA,
    output logic [1:0]       RRESP,
    output logic             RVALID,
    input  wire logic        RREADY,
    // Outputs to the queue engine.
    output logic [31:0]      NEGOTIATED_FEATURES,
    output logic [15:0]      ACTIVE_QUEUE_PAIRS,
    output logic [16:0]      CONTROL_QUEUE_INDEX,
    output logic [47:0]      STATION_ADDR_OUT
);
    logic [31:0]              offered;       // Feature word shown to the driver.
    logic [31:0]              accepted;      // Last legal driver acceptance.
    logic [2:0]               control;       // Legacy, link and announce controls.
    net_cfg_pkg::neg_result_t neg_result;    // Outcome of last acceptance.
    logic [47:0]              station_addr;  // Address register, legacy writable.
    logic                     addr_loaded;   // Address captured after reset.
    logic [15:0]              max_qp;        // Clamped queue-pair maximum.
    logic [15:0]              active_qp;     // Pairs in use.
    logic [15:0]              status_word;   // Link and announce status.
    logic [15:0]              stat_ord;      // Status in driver order.
    logic [15:0]              qp_ord;        // Queue-pair field in driver order.
    logic                     aw_held;       // Write address taken.
    logic                     w_held;        // Write data taken.
    logic [11:0]              aw_addr;       // Latched write address.
    logic [31:0]              w_data;        // Latched write data.
    logic [3:0]               w_strb;        // Latched byte enables.
    logic                     wr_fire;       // Write performed this cycle.
    logic                     wr_ok;         // Write address decoded.
    logic                     deps_bad;      // Driver word breaks dependencies.
    net_cfg_pkg::rd_state_t   rd_state;      // Read channel state.
    logic [31:0]              rd_word;       // Decoded read value.
    logic                     rd_hit;        // Read address decoded.

    // True when a word holds a feature without its prerequisite.
    function automatic logic deps_broken(input logic [31:0] f);
        logic bad;
        bad = 1'b0;
        if ((f[`FEAT_DRV_TCP4_SEG] | f[`FEAT_DRV_TCP6_SEG] | f[`FEAT_DRV_UDP_FRAG])
            & ~f[`FEAT_DRV_CSUM]) bad = 1'b1;
        if ((f[`FEAT_DEV_TCP4_SEG] | f[`FEAT_DEV_TCP6_SEG] | f[`FEAT_DEV_UDP_FRAG])
            & ~f[`FEAT_DEV_CSUM]) bad = 1'b1;
        if ((f[`FEAT_CTRL_RX_MODE] | f[`FEAT_CTRL_VLAN] | f[`FEAT_DRV_ANNOUNCE]
            | f[`FEAT_MULTIQUEUE] | f[`FEAT_CTRL_ADDR_SET]) & ~f[`FEAT_CTRL_QUEUE])
            bad = 1'b1;
        if (f[`FEAT_DRV_CONG_SEG] & ~(f[`FEAT_DRV_TCP4_SEG] | f[`FEAT_DRV_TCP6_SEG]))
            bad = 1'b1;
        if (f[`FEAT_DEV_CONG_SEG] & ~(f[`FEAT_DEV_TCP4_SEG] | f[`FEAT_DEV_TCP6_SEG]))
            bad = 1'b1;
        return bad;
    endfunction : deps_broken

    // Byte swap for a big-endian native guest order.
    function automatic logic [15:0] to_driver_order(input logic [15:0] v,
                                                    input logic        swap);
        return swap ? {v[7:0], v[15:8]} : v;
    endfunction : to_driver_order

    // Offered word: defined positions only; a dependent bit is
    // dropped unless its prerequisite is offered too.
    always_comb begin
        offered = 32'h0000_0000;
        offered[`FEAT_DEV_CSUM]       = DEV_FEATURES[`FEAT_DEV_CSUM];
        offered[`FEAT_DRV_CSUM]       = DEV_FEATURES[`FEAT_DRV_CSUM];
        offered[`FEAT_OFFLOAD_CTRL]   = DEV_FEATURES[`FEAT_OFFLOAD_CTRL];
        offered[`FEAT_STATION_ADDR]   = DEV_FEATURES[`FEAT_STATION_ADDR];
        // The catch-all segmentation bit exists only in legacy mode.
        offered[`FEAT_ANY_SEG_LEGACY] = DEV_FEATURES[`FEAT_ANY_SEG_LEGACY]
                                        & control[`CTL_LEGACY];
        offered[`FEAT_DRV_TCP4_SEG]   = DEV_FEATURES[`FEAT_DRV_TCP4_SEG]
                                        & DEV_FEATURES[`FEAT_DRV_CSUM];
        offered[`FEAT_DRV_TCP6_SEG]   = DEV_FEATURES[`FEAT_DRV_TCP6_SEG]
                                        & DEV_FEATURES[`FEAT_DRV_CSUM];
        offered[`FEAT_DRV_UDP_FRAG]   = DEV_FEATURES[`FEAT_DRV_UDP_FRAG]
                                        & DEV_FEATURES[`FEAT_DRV_CSUM];
        offered[`FEAT_DRV_CONG_SEG]   = DEV_FEATURES[`FEAT_DRV_CONG_SEG]
                                        & (offered[`FEAT_DRV_TCP4_SEG]
                                           | offered[`FEAT_DRV_TCP6_SEG]);
        offered[`FEAT_DEV_TCP4_SEG]   = DEV_FEATURES[`FEAT_DEV_TCP4_SEG]
                                        & DEV_FEATURES[`FEAT_DEV_CSUM];
        offered[`FEAT_DEV_TCP6_SEG]   = DEV_FEATURES[`FEAT_DEV_TCP6_SEG]
                                        & DEV_FEATURES[`FEAT_DEV_CSUM];
        offered[`FEAT_DEV_UDP_FRAG]   = DEV_FEATURES[`FEAT_DEV_UDP_FRAG]
                                        & DEV_FEATURES[`FEAT_DEV_CSUM];
        offered[`FEAT_DEV_CONG_SEG]   = DEV_FEATURES[`FEAT_DEV_CONG_SEG]
                                        & (offered[`FEAT_DEV_TCP4_SEG]
                                           | offered[`FEAT_DEV_TCP6_SEG]);
        offered[`FEAT_MERGE_RX]       = DEV_FEATURES[`FEAT_MERGE_RX];
        offered[`FEAT_STATUS]         = DEV_FEATURES[`FEAT_STATUS];
        offered[`FEAT_CTRL_QUEUE]     = DEV_FEATURES[`FEAT_CTRL_QUEUE];
        offered[`FEAT_CTRL_RX_MODE]   = DEV_FEATURES[`FEAT_CTRL_RX_MODE]
                                        & DEV_FEATURES[`FEAT_CTRL_QUEUE];
        offered[`FEAT_CTRL_VLAN]      = DEV_FEATURES[`FEAT_CTRL_VLAN]
                                        & DEV_FEATURES[`FEAT_CTRL_QUEUE];
        offered[`FEAT_DRV_ANNOUNCE]   = DEV_FEATURES[`FEAT_DRV_ANNOUNCE]
                                        & DEV_FEATURES[`FEAT_CTRL_QUEUE];
        offered[`FEAT_MULTIQUEUE]     = DEV_FEATURES[`FEAT_MULTIQUEUE]
                                        & DEV_FEATURES[`FEAT_CTRL_QUEUE];
        offered[`FEAT_CTRL_ADDR_SET]  = DEV_FEATURES[`FEAT_CTRL_ADDR_SET]
                                        & DEV_FEATURES[`FEAT_CTRL_QUEUE];
    end

    // Clamped so software never sees an out-of-range maximum.
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            max_qp <= `QP_MIN;
        end else if (MAX_QP_IN < `QP_MIN) begin
            max_qp <= `QP_MIN;
        end else if (MAX_QP_IN > `QP_MAX) begin
            max_qp <= `QP_MAX;
        end else begin
            max_qp <= MAX_QP_IN;
        end
    end

    // Status bits exist only when the status feature is offered.
    assign status_word = offered[`FEAT_STATUS] ?
        ((control[`CTL_LINK_UP] ? `LINK_UP_VAL : 16'h0000) |
         (control[`CTL_ANNOUNCE] ? `ANNOUNCE_VAL : 16'h0000)) : 16'h0000;
    assign stat_ord = to_driver_order(status_word,
                                      control[`CTL_LEGACY] & NATIVE_BIG_ENDIAN);
    assign qp_ord   = to_driver_order(offered[`FEAT_MULTIQUEUE] ? max_qp : 16'h0000,
                                      control[`CTL_LEGACY] & NATIVE_BIG_ENDIAN);

    // Write channel: address and data are taken in either order and held.
    assign AWREADY = ~aw_held & ~BVALID;
    assign WREADY  = ~w_held & ~BVALID;
    assign wr_fire = aw_held & w_held & ~BVALID;
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            aw_held <= 1'b0;
            aw_addr <= 12'h000;
        end else if (AWVALID && AWREADY) begin
            aw_held <= 1'b1;
            aw_addr <= AWADDR;
        end else if (wr_fire) begin
            aw_held <= 1'b0;
        end
    end
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else if (WVALID && WREADY) begin
            w_held <= 1'b1;
            w_data <= WDATA;
            w_strb <= WSTRB;
        end else if (wr_fire) begin
            w_held <= 1'b0;
        end
    end

    // Writable addresses; address words only in legacy mode.
    always_comb begin
        case (aw_addr)
            `OFF_DRV_FEAT, `OFF_CONTROL, `OFF_QP_CMD: wr_ok = 1'b1;
            `OFF_CFG_WORD0, `OFF_CFG_WORD1: wr_ok = control[`CTL_LEGACY];
            default: wr_ok = 1'b0;
        endcase
    end

    // Write response; an unmapped or read-only target answers with an error.
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            BVALID <= 1'b0;
            BRESP  <= `RESP_OKAY;
        end else if (wr_fire) begin
            BVALID <= 1'b1;
            BRESP  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
        end else if (BREADY) begin
            BVALID <= 1'b0;
        end
    end

    // A broken acceptance is refused whole and the previous set stays,
    // so the queue engine never sees an illegal mix.
    assign deps_bad = deps_broken(w_data & offered);
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            accepted   <= 32'h0000_0000;
            neg_result <= net_cfg_pkg::NEG_NONE;
        end else if (wr_fire && aw_addr == `OFF_DRV_FEAT) begin
            if (deps_bad || (w_data & ~offered) != 32'h0000_0000) begin
                neg_result <= net_cfg_pkg::NEG_REJECT;
            end else begin
                accepted   <= w_data;
                neg_result <= net_cfg_pkg::NEG_OK;
            end
        end
    end

    // Control register: legacy, link and announce.
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            control <= 3'h0;
        end else if (wr_fire && aw_addr == `OFF_CONTROL && w_strb[0]) begin
            control <= w_data[2:0];
        end
    end

    // One pair only until the pair command, with multiqueue negotiated;
    // out-of-range requests are ignored.
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            active_qp <= `QP_MIN;
        end else if (!accepted[`FEAT_MULTIQUEUE]) begin
            active_qp <= `QP_MIN;
        end else if (wr_fire && aw_addr == `OFF_QP_CMD
                     && w_data[15:0] >= `QP_MIN && w_data[15:0] <= max_qp) begin
            active_qp <= w_data[15:0];
        end
    end

    // Address captured after reset; legacy writes update bytes.
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            station_addr <= 48'h0000_0000_0000;
            addr_loaded  <= 1'b0;
        end else if (!addr_loaded) begin
            station_addr <= STATION_ADDR_IN;
            addr_loaded  <= 1'b1;
        end else if (wr_fire && wr_ok && aw_addr == `OFF_CFG_WORD0) begin
            for (int i = 0; i < 4; i++) begin
                if (w_strb[i]) station_addr[8*i +: 8] <= w_data[8*i +: 8];
            end
        end else if (wr_fire && wr_ok && aw_addr == `OFF_CFG_WORD1) begin
            for (int i = 0; i < 2; i++) begin
                if (w_strb[i]) station_addr[32+8*i +: 8] <= w_data[8*i +: 8];
            end
        end
    end

    // Read decode; config bytes packed into little-endian words.
    always_comb begin
        rd_hit = 1'b1;
        case (ARADDR)
            `OFF_DEV_FEAT:   rd_word = offered;
            `OFF_DRV_FEAT:   rd_word = accepted;
            `OFF_CONTROL:    rd_word = {29'h0000_0000, control};
            `OFF_NEG_STATUS: rd_word = {30'h0000_0000, neg_result};
            `OFF_QP_CMD:     rd_word = {16'h0000, active_qp};
            `OFF_ACTIVE_QP:  rd_word = {16'h0000, active_qp};
            `OFF_CFG_WORD0:  rd_word = station_addr[31:0];
            `OFF_CFG_WORD1:  rd_word = {stat_ord, station_addr[47:32]};
            `OFF_CFG_WORD2:  rd_word = {16'h0000, qp_ord};
            default: begin
                rd_word = 32'h0000_0000;
                rd_hit  = 1'b0;
            end
        endcase
    end

    // Read channel: answer one cycle on, held until taken.
    assign ARREADY = (rd_state == net_cfg_pkg::RD_IDLE);
    assign RVALID  = (rd_state == net_cfg_pkg::RD_RESP);
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            rd_state <= net_cfg_pkg::RD_IDLE;
            RDATA    <= 32'h0000_0000;
            RRESP    <= `RESP_OKAY;
        end else begin
            case (rd_state)
                net_cfg_pkg::RD_IDLE: begin
                    if (ARVALID) begin
                        rd_state <= net_cfg_pkg::RD_RESP;
                        RDATA    <= rd_word;
                        RRESP    <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
                    end
                end
                net_cfg_pkg::RD_RESP: begin
                    if (RREADY) rd_state <= net_cfg_pkg::RD_IDLE;
                end
                default: rd_state <= net_cfg_pkg::RD_IDLE;
            endcase
        end
    end

    // Outputs to the queue engine: control queue sits at 2N+2.
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            NEGOTIATED_FEATURES <= 32'h0000_0000;
            ACTIVE_QUEUE_PAIRS  <= `QP_MIN;
            CONTROL_QUEUE_INDEX <= 17'h00000;
            STATION_ADDR_OUT    <= 48'h0000_0000_0000;
        end else begin
            NEGOTIATED_FEATURES <= accepted;
            ACTIVE_QUEUE_PAIRS  <= active_qp;
            CONTROL_QUEUE_INDEX <= {(accepted[`FEAT_MULTIQUEUE] ? max_qp : `QP_MIN), 1'b0}
                                   + 17'h00002;
            STATION_ADDR_OUT    <= station_addr;
        end
    end
endmodule : net_feature_config_space

/* File: verification/net_cfg_checker_asserts.sv */
`timescale 1ns/100ps
// Watches the bus handshakes and the negotiated outputs.
module net_cfg_checker (
    // Clock and reset.
    input wire logic        CLK,
    input wire logic        RSTN,
    // Bus handshakes.
    input wire logic        AWREADY,
    input wire logic        WREADY,
    input wire logic [1:0]  BRESP,
    input wire logic        BVALID,
    input wire logic        BREADY,
    input wire logic        ARVALID,
    input wire logic        ARREADY,
    input wire logic [31:0] RDATA,
    input wire logic        RVALID,
    input wire logic        RREADY,
    // Negotiated outputs.
    input wire logic [31:0] NEGOTIATED_FEATURES,
    input wire logic [15:0] ACTIVE_QUEUE_PAIRS,
    input wire logic [16:0] CONTROL_QUEUE_INDEX
);
    // Short alias of the accepted word.
    wire logic [31:0] nf = NEGOTIATED_FEATURES;
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RSTN);
    // An answer stands until the master takes it.
    AST_WR_HOLD: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
        else $error("write response not held");
    AST_WR_BLOCK: assert property (BVALID |-> !AWREADY && !WREADY)
        else $error("write taken while answer pending");
    AST_RD_NEXT: assert property (ARVALID && ARREADY |=> RVALID && !ARREADY)
        else $error("read answer late or read taken early");
    AST_RD_HOLD: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
        else $error("read answer not held");
    // The accepted word keeps every prerequisite.
    AST_DEP_PREREQ: assert property ((!(nf[7] || nf[8] || nf[10]) || nf[1]) &&
        (!(nf[11] || nf[12] || nf[14]) || nf[0]) && (!(|{nf[23:21], nf[19:18]}) || nf[17]))
        else $error("accepted feature lacks its prerequisite");
    AST_CONG_PREREQ: assert property ((!nf[9] || nf[7] || nf[8]) &&
        (!nf[13] || nf[11] || nf[12]))
        else $error("congestion bit without segmentation");
    AST_QP_RANGE: assert property (ACTIVE_QUEUE_PAIRS >= 16'h0001 &&
        ACTIVE_QUEUE_PAIRS <= 16'h8000)
        else $error("active queue pairs out of range");
    // One cycle of slack for the fall back after renegotiation.
    AST_QP_SINGLE: assert property (ACTIVE_QUEUE_PAIRS != 16'h0001 |->
        nf[22] || $past(nf[22]))
        else $error("several pairs without multiqueue");
    AST_CTRL_IDX: assert property (!nf[22] && !$past(nf[22]) && $past(RSTN) |->
        CONTROL_QUEUE_INDEX == 17'h00004)
        else $error("control queue index wrong");
endmodule : net_cfg_checker

/* File: verification/test_net_feature_config_space.sv */
`timescale 1ns/100ps
`include "net_cfg_defs.svh"
module test_net_feature_config_space;
    logic        CLK, RSTN, NATIVE_BIG_ENDIAN, AWVALID, AWREADY, WVALID, WREADY;
    logic        BVALID, BREADY, ARVALID, ARREADY, RVALID, RREADY;
    logic [31:0] DEV_FEATURES, WDATA, RDATA, NEGOTIATED_FEATURES;
    logic [47:0] STATION_ADDR_IN, STATION_ADDR_OUT;
    logic [15:0] MAX_QP_IN, ACTIVE_QUEUE_PAIRS;
    logic [11:0] AWADDR, ARADDR;
    logic [3:0]  WSTRB;
    logic [1:0]  BRESP, RRESP, r;
    logic [16:0] CONTROL_QUEUE_INDEX;
    logic [31:0] bad [4] = '{32'h00400000, 32'h00002001, 32'h00000080, 32'h00100000};
    int          fails, n_tests;
    net_feature_config_space u_dut (.CLK(CLK), .RSTN(RSTN), .DEV_FEATURES(DEV_FEATURES),
        .STATION_ADDR_IN(STATION_ADDR_IN), .MAX_QP_IN(MAX_QP_IN),
        .NATIVE_BIG_ENDIAN(NATIVE_BIG_ENDIAN), .AWADDR(AWADDR), .AWVALID(AWVALID),
        .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
        .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
        .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
        .NEGOTIATED_FEATURES(NEGOTIATED_FEATURES), .ACTIVE_QUEUE_PAIRS(ACTIVE_QUEUE_PAIRS),
        .CONTROL_QUEUE_INDEX(CONTROL_QUEUE_INDEX), .STATION_ADDR_OUT(STATION_ADDR_OUT));
    // Free-running 125 MHz clock.
    initial begin
        CLK = 1'h0;
        forever #4 CLK = ~CLK;
    end
    // Compares one data word.
    task automatic chk_data(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_data
    // Compares one answer code.
    task automatic chk_resp(input string nm, input logic [1:0] e, input logic [1:0] g);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_resp
    // Write: ready is sampled mid-cycle; bready comes late to test the hold.
    task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] rs);
        logic pa = 1'h1, pw = 1'h1, ha, hw, b = 1'h0;
        @(posedge CLK);
        AWADDR <= a; WDATA <= d; WSTRB <= 4'hF;
        AWVALID <= 1'h1; WVALID <= 1'h1;
        while (pa || pw) begin
            @(negedge CLK);
            ha = pa && AWREADY; hw = pw && WREADY;
            @(posedge CLK);
            if (ha) begin AWVALID <= 1'h0; pa = 1'h0; end
            if (hw) begin WVALID <= 1'h0; pw = 1'h0; end
        end
        repeat (2) @(posedge CLK);
        BREADY <= 1'h1;
        while (!b) begin
            @(negedge CLK);
            b = BVALID; rs = BRESP;
            @(posedge CLK);
        end
        BREADY <= 1'h0;
    endtask : wr
    // Writes a word, checks the answer code.
    task automatic wchk(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
        wr(a, d, r);
        chk_resp($sformatf("bresp %h", a), e, r);
    endtask : wchk
    // Reads a word, checks data and answer code.
    task automatic rchk(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
        logic h = 1'h0, v = 1'h0;
        logic [31:0] d;
        logic [1:0] rs;
        @(posedge CLK);
        ARADDR <= a; ARVALID <= 1'h1;
        while (!h) begin @(negedge CLK); h = ARREADY; @(posedge CLK); end
        ARVALID <= 1'h0;
        @(posedge CLK);
        RREADY <= 1'h1;
        while (!v) begin @(negedge CLK); v = RVALID; d = RDATA; rs = RRESP; @(posedge CLK); end
        RREADY <= 1'h0;
        chk_resp($sformatf("rresp %h", a), er, rs);
        chk_data($sformatf("rdata %h", a), e, d);
    endtask : rchk
    // New capability inputs, then time for the capture.
    task automatic setdev(input logic [31:0] f, input logic [15:0] q, input logic be);
        @(posedge CLK);
        DEV_FEATURES <= f; MAX_QP_IN <= q; NATIVE_BIG_ENDIAN <= be;
        repeat (2) @(posedge CLK);
    endtask : setdev
    // Prints counts and verdict, then stops.
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : final_report
    // Watchdog: the tests need far fewer cycles.
    initial begin
        repeat (20000) @(posedge CLK);
        fails++;
        final_report();
    end
    initial begin
        RSTN = 1'h0; DEV_FEATURES = 32'hFFFFFFFF; MAX_QP_IN = 16'h0004;
        STATION_ADDR_IN = 48'hA1B2C3D4E5F6; NATIVE_BIG_ENDIAN = 1'h0;
        AWADDR = 12'h000; AWVALID = 1'h0; WDATA = 32'h0; WSTRB = 4'h0; WVALID = 1'h0;
        BREADY = 1'h0; ARADDR = 12'h000; ARVALID = 1'h0; RREADY = 1'h0;
        repeat (2) @(posedge CLK);
        RSTN <= 1'h1;
        rchk(`OFF_NEG_STATUS, 32'h0, `RESP_OKAY);
        rchk(`OFF_ACTIVE_QP, 32'h1, `RESP_OKAY);
        rchk(`OFF_DEV_FEAT, 32'h00EFFFA7, `RESP_OKAY);
        rchk(`OFF_CFG_WORD0, 32'hC3D4E5F6, `RESP_OKAY);
        rchk(`OFF_CFG_WORD1, 32'h0000A1B2, `RESP_OKAY);
        rchk(`OFF_CFG_WORD2, 32'h00000004, `RESP_OKAY);
        wchk(`OFF_CONTROL, 32'h6, `RESP_OKAY);
        rchk(`OFF_CFG_WORD1, 32'h0003A1B2, `RESP_OKAY);
        wchk(`OFF_CFG_WORD0, 32'h11223344, `RESP_SLVERR);
        wchk(`OFF_DEV_FEAT, 32'h0, `RESP_SLVERR);
        rchk(12'h200, 32'h0, `RESP_SLVERR);
        // Legacy: bit 6 offered, address writable, native order.
        wchk(`OFF_CONTROL, 32'h7, `RESP_OKAY);
        rchk(`OFF_DEV_FEAT, 32'h00EFFFE7, `RESP_OKAY);
        wchk(`OFF_CFG_WORD0, 32'h11223344, `RESP_OKAY);
        rchk(`OFF_CFG_WORD0, 32'h11223344, `RESP_OKAY);
        setdev(32'hFFFFFFFF, 16'h0004, 1'h1);
        rchk(`OFF_CFG_WORD1, 32'h0300A1B2, `RESP_OKAY);
        rchk(`OFF_CFG_WORD2, 32'h00000400, `RESP_OKAY);
        wchk(`OFF_CONTROL, 32'h0, `RESP_OKAY);
        // Dependents vanish with their prerequisites.
        setdev(32'hFFFDFFFD, 16'h0004, 1'h0);
        rchk(`OFF_DEV_FEAT, 32'h0001F825, `RESP_OKAY);
        setdev(32'hFFFFFE7F, 16'h0000, 1'h0);
        rchk(`OFF_DEV_FEAT, 32'h00EFFC27, `RESP_OKAY);
        rchk(`OFF_CFG_WORD2, 32'h00000001, `RESP_OKAY);
        setdev(32'hFFBFFFFF, 16'hFFFF, 1'h0);
        rchk(`OFF_CFG_WORD2, 32'h00000000, `RESP_OKAY);
        setdev(32'hFFFFFFFF, 16'hFFFF, 1'h0);
        rchk(`OFF_CFG_WORD2, 32'h00008000, `RESP_OKAY);
        setdev(32'hFFFFFFFF, 16'h0004, 1'h0);
        // Multiqueue: one pair until the pair command.
        wchk(`OFF_DRV_FEAT, 32'h00420020, `RESP_OKAY);
        rchk(`OFF_NEG_STATUS, 32'h1, `RESP_OKAY);
        repeat (2) @(posedge CLK);
        chk_data("negotiated", 32'h00420020, NEGOTIATED_FEATURES);
        chk_data("ctrl index", 32'h0000000A, {15'h0, CONTROL_QUEUE_INDEX});
        chk_data("station addr", 32'h11223344, STATION_ADDR_OUT[31:0]);
        rchk(`OFF_ACTIVE_QP, 32'h1, `RESP_OKAY);
        wchk(`OFF_QP_CMD, 32'h3, `RESP_OKAY);
        rchk(`OFF_ACTIVE_QP, 32'h3, `RESP_OKAY);
        wr(`OFF_QP_CMD, 32'h5, r);
        rchk(`OFF_ACTIVE_QP, 32'h3, `RESP_OKAY);
        chk_data("active pairs", 32'h3, {16'h0, ACTIVE_QUEUE_PAIRS});
        // Broken acceptances refused, previous word kept.
        foreach (bad[i]) begin
            wr(`OFF_DRV_FEAT, bad[i], r);
            rchk(`OFF_NEG_STATUS, 32'h2, `RESP_OKAY);
        end
        chk_data("negotiated kept", 32'h00420020, NEGOTIATED_FEATURES);
        wchk(`OFF_DRV_FEAT, 32'h00000001, `RESP_OKAY);
        repeat (2) @(posedge CLK);
        chk_data("ctrl index", 32'h00000004, {15'h0, CONTROL_QUEUE_INDEX});
        wr(`OFF_QP_CMD, 32'h2, r);
        rchk(`OFF_ACTIVE_QP, 32'h1, `RESP_OKAY);
        // A mid-run reset clears the negotiation.
        RSTN <= 1'h0;
        repeat (2) @(posedge CLK);
        RSTN <= 1'h1;
        rchk(`OFF_NEG_STATUS, 32'h0, `RESP_OKAY);
        chk_data("negotiated reset", 32'h0, NEGOTIATED_FEATURES);
        final_report();
    end
endmodule : test_net_feature_config_space
bind net_feature_config_space net_cfg_checker u_chk (.CLK(CLK), .RSTN(RSTN),
    .AWREADY(AWREADY), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
    .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RVALID(RVALID), .RREADY(RREADY),
    .NEGOTIATED_FEATURES(NEGOTIATED_FEATURES), .ACTIVE_QUEUE_PAIRS(ACTIVE_QUEUE_PAIRS),
    .CONTROL_QUEUE_INDEX(CONTROL_QUEUE_INDEX));
